//--- inc/mxsc_link_if.sv
`timescale 1ns/1ns
interface mxsc_link_if;
  logic sync_n;
  logic sclk;
  logic din;

  modport host (output sync_n, output sclk, output din);
  modport dev  (input  sync_n, input  sclk, input  din);
endinterface

//--- inc/mxsc_pkg.sv
package mxsc_pkg;

  // ----------------------------------------------------------------
  // Clock and link timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          T4_NS         = 13;
  localparam int          T4_CYC_INT    = (T4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  T4_CYC        = T4_CYC_INT[3:0];
  localparam logic [3:0]  SCLK_HALF_CYC = 4'h4;
  localparam logic [3:0]  SETUP_CYC     = (T4_CYC > SCLK_HALF_CYC) ? T4_CYC : SCLK_HALF_CYC;
  localparam logic [3:0]  GAP_CYC       = 4'h4;

  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int          WORD_W        = 8;
  localparam logic [2:0]  LAST_BIT_IDX  = 3'h7;
  localparam int          EN_N_BIT      = 7;
  localparam int          BANK_A_SEL_N  = 6;
  localparam int          BANK_B_SEL_N  = 5;
  localparam int          CHAN32_MSB    = 4;
  localparam int          CHAN16_MSB    = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  WORD_RST      = 8'h00;
  localparam logic [4:0]  CHAN_RST      = 5'h00;
  localparam logic [2:0]  PINS_IDLE     = 3'h4;

  typedef enum logic [2:0] {
    MXSC_IDLE  = 3'b000,
    MXSC_SETUP = 3'b001,
    MXSC_HIGH  = 3'b011,
    MXSC_LOW   = 3'b010,
    MXSC_GAP   = 3'b110
  } mxsc_host_st_t;

  // One-cycle falling edge between a delayed copy and the current level
  function automatic logic mxsc_fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

endpackage

//--- logic/mxsc_dev.sv
`timescale 1ns/1ns
module mxsc_dev
  import mxsc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  mxsc_link_if.dev         link,
  input  wire logic        dual_mode_i,
  output logic             frame_active_o,
  output logic             update_o,
  output logic             abort_o,
  output logic [7:0]       cfg_word_o,
  output logic [4:0]       mux_chan_o,
  output logic             mux_on_o,
  output logic [3:0]       bank_a_chan_o,
  output logic             bank_a_on_o,
  output logic [3:0]       bank_b_chan_o,
  output logic             bank_b_on_o
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  // The host logic may sit on another clock in a real system, so
  // every pin is resynchronised before any edge detection.
  logic [2:0] pins_s;

  mxsc_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .d_i       ({link.sync_n, link.sclk, link.din}),
    .q_o       (pins_s)
  );

  wire sync_n_s = pins_s[2];
  wire sclk_s   = pins_s[1];
  wire din_s    = pins_s[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       sync_n_q;
  logic       sclk_q;
  logic       active_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shreg_q;

  // ----------------------------------------------------------------
  // Edge and frame decoding
  // ----------------------------------------------------------------
  wire sclk_fall   = mxsc_fell(sclk_q, sclk_s);
  wire at_last     = (bit_cnt_q == LAST_BIT_IDX);
  wire frame_start = mxsc_fell(sync_n_q, sync_n_s);
  wire frame_abort = active_q & sync_n_s & ~(sclk_fall & at_last);
  wire shift_edge  = active_q & ~frame_start & sclk_fall & (~sync_n_s | at_last);
  wire last_edge   = shift_edge & at_last;
  wire [7:0] word_next = {shreg_q[6:0], din_s};

  // The select level is ignored on the eighth edge: a release seen in
  // the same cycle as that edge still loads the word, and the load
  // never waits for select to rise.
  wire do_update = last_edge;

  // ----------------------------------------------------------------
  // Word field decoding
  // ----------------------------------------------------------------
  wire       sw_on     = ~word_next[EN_N_BIT];
  wire       load_a    = do_update & (~dual_mode_i | ~word_next[BANK_A_SEL_N]);
  wire       load_b    = do_update & dual_mode_i & ~word_next[BANK_B_SEL_N];
  wire [4:0] chan32    = word_next[CHAN32_MSB:0];
  wire [3:0] chan16    = word_next[CHAN16_MSB:0];

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sync_n_q <= PINS_IDLE[2];
      sclk_q   <= PINS_IDLE[1];
    end
    else if (ce_i)
    begin
      sync_n_q <= sync_n_s;
      sclk_q   <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Frame control and bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      active_q  <= 1'b0;
      bit_cnt_q <= 3'h0;
    end
    else if (ce_i)
    begin
      if (frame_start)
      begin
        active_q  <= 1'b1;
        bit_cnt_q <= 3'h0;
      end
      else if (frame_abort || last_edge)
      begin
        active_q  <= 1'b0;
      end
      else if (shift_edge)
      begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input shift register
  // ----------------------------------------------------------------
  // A partial word is left in the shifter on abort; it is never copied
  // out and the next frame overwrites all eight bits anyway.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      shreg_q <= WORD_RST;
    else if (ce_i && shift_edge)
      shreg_q <= word_next;
  end

  // ----------------------------------------------------------------
  // Switch configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cfg_word_o <= WORD_RST;
      mux_chan_o <= CHAN_RST;
      mux_on_o   <= 1'b0;
    end
    else if (ce_i && do_update)
    begin
      cfg_word_o <= word_next;
      mux_chan_o <= chan32;
      mux_on_o   <= sw_on & ~dual_mode_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      bank_a_chan_o <= CHAN_RST[3:0];
      bank_a_on_o   <= 1'b0;
    end
    else if (ce_i && load_a && dual_mode_i)
    begin
      bank_a_chan_o <= chan16;
      bank_a_on_o   <= sw_on;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      bank_b_chan_o <= CHAN_RST[3:0];
      bank_b_on_o   <= 1'b0;
    end
    else if (ce_i && load_b)
    begin
      bank_b_chan_o <= chan16;
      bank_b_on_o   <= sw_on;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      frame_active_o <= 1'b0;
      update_o       <= 1'b0;
      abort_o        <= 1'b0;
    end
    else if (ce_i)
    begin
      frame_active_o <= (active_q & ~frame_abort & ~last_edge) | frame_start;
      update_o       <= do_update;
      abort_o        <= frame_abort;
    end
  end

endmodule // mxsc_dev

//--- logic/mxsc_host.sv
`timescale 1ns/1ns
module mxsc_host
  import mxsc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  word_i,
  output logic             ready_o,
  output logic             done_o,
  mxsc_link_if.host        link
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mxsc_host_st_t state_q, state_d;
  logic [3:0]    tm_q, tm_d;
  logic [2:0]    bits_q, bits_d;
  logic [7:0]    shift_q, shift_d;
  logic          sync_n_q, sync_n_d;
  logic          sclk_q, sclk_d;
  logic          din_q, din_d;
  logic          ready_d, done_d;

  wire tm_end   = (tm_q == 4'h1);
  wire last_bit = (bits_q == LAST_BIT_IDX);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // The clock idles low between frames so the switches see no
  // digital activity outside a transfer. Only one select line is
  // driven here; sharing clock and data among several devices needs
  // one select per device, asserted one at a time.
  always_comb
  begin
    state_d  = state_q;
    tm_d     = tm_end ? tm_q : tm_q - 4'h1;
    bits_d   = bits_q;
    shift_d  = shift_q;
    sync_n_d = sync_n_q;
    sclk_d   = sclk_q;
    din_d    = din_q;
    ready_d  = ready_o;
    done_d   = 1'b0;
    case (state_q)
      MXSC_IDLE:
      begin
        if (start_i)
        begin
          state_d  = MXSC_SETUP;
          sync_n_d = 1'b0;
          shift_d  = word_i;
          bits_d   = 3'h0;
          tm_d     = SETUP_CYC;
          ready_d  = 1'b0;
        end
      end
      MXSC_SETUP:
      begin
        if (tm_end)
        begin
          state_d = MXSC_HIGH;
          sclk_d  = 1'b1;
          din_d   = shift_q[7];
          tm_d    = SCLK_HALF_CYC;
        end
      end
      MXSC_HIGH:
      begin
        if (tm_end)
        begin
          state_d = MXSC_LOW;
          sclk_d  = 1'b0;
          shift_d = {shift_q[6:0], 1'b0};
          tm_d    = SCLK_HALF_CYC;
        end
      end
      MXSC_LOW:
      begin
        if (tm_end && last_bit)
        begin
          state_d  = MXSC_GAP;
          sync_n_d = 1'b1;
          tm_d     = GAP_CYC;
        end
        else if (tm_end)
        begin
          state_d = MXSC_HIGH;
          bits_d  = bits_q + 3'h1;
          sclk_d  = 1'b1;
          din_d   = shift_q[7];
          tm_d    = SCLK_HALF_CYC;
        end
      end
      MXSC_GAP:
      begin
        if (tm_end)
        begin
          state_d = MXSC_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end
      end
      default:
      begin
        state_d  = MXSC_IDLE;
        sync_n_d = 1'b1;
        sclk_d   = 1'b0;
        ready_d  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_q  <= MXSC_IDLE;
      tm_q     <= 4'h1;
      bits_q   <= 3'h0;
      shift_q  <= WORD_RST;
      sync_n_q <= 1'b1;
      sclk_q   <= 1'b0;
      din_q    <= 1'b0;
      ready_o  <= 1'b1;
      done_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      state_q  <= state_d;
      tm_q     <= tm_d;
      bits_q   <= bits_d;
      shift_q  <= shift_d;
      sync_n_q <= sync_n_d;
      sclk_q   <= sclk_d;
      din_q    <= din_d;
      ready_o  <= ready_d;
      done_o   <= done_d;
    end
  end

  assign link.sync_n = sync_n_q;
  assign link.sclk   = sclk_q;
  assign link.din    = din_q;

endmodule // mxsc_host

//--- logic/mxsc_sync.sv
`timescale 1ns/1ns
module mxsc_sync
  import mxsc_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [2:0] d_i,
  output logic      [2:0] q_o
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser, first stage read only by the second
  // ----------------------------------------------------------------
  logic [2:0] meta_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      meta_q <= PINS_IDLE;
      q_o    <= PINS_IDLE;
    end
    else if (ce_i)
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule // mxsc_sync

//--- testbench/mxsc_link_asserts.sv
`timescale 1ns/1ns
module mxsc_link_asserts
  import mxsc_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       start_i,
  input wire logic       ready_o,
  input wire logic       done_o,
  input wire logic       sync_n,
  input wire logic       sclk,
  input wire logic       din,
  input wire logic       update_o,
  input wire logic       abort_o,
  input wire logic       frame_active_o,
  input wire logic [7:0] cfg_word_o,
  input wire logic       mux_on_o
);
  // ----------------------------------------------------------------
  // Link checks, host and device joined
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    start_i && ready_o;
  endsequence

  // Select seen low after two sync stages, shifting stops after the eighth fall
  sequence s_frame;
    ##4 frame_active_o ##64 !frame_active_o;
  endsequence

  a_frame_start: assert property (s_take |=> !sync_n)
    else $error("select did not fall after start");
  a_done_time: assert property (s_take |-> ##73 done_o)
    else $error("frame did not end on time");
  a_ready_busy: assert property (s_take |=> !ready_o [*8])
    else $error("host took a second word in one frame");
  a_sclk_idle: assert property (sync_n |-> !sclk)
    else $error("serial clock runs outside a frame");
  a_din_hold: assert property ($fell(sclk) |-> $stable(din))
    else $error("data moved at the sampling edge");
  a_cfg_update: assert property ($changed(cfg_word_o) |-> update_o)
    else $error("config changed without update pulse");
  a_frame_window: assert property (s_take |-> s_frame)
    else $error("frame active window has the wrong length");
  a_update_time: assert property (s_take |-> ##68 update_o)
    else $error("update not on the eighth falling edge");
  a_update_no_wait: assert property (update_o |-> !$past(sync_n))
    else $error("update waited for select release");
  a_no_abort: assert property (!abort_o)
    else $error("complete frame was dropped");
  // Checked at the first edge after release, since reset disables all
  a_reset_clear: assert property ($fell(rst_i) |-> cfg_word_o == WORD_RST && !mux_on_o)
    else $error("switches not off after reset");
endmodule // mxsc_link_asserts

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import mxsc_pkg::*;
  logic       clk_sys_i   = 1'b0;
  logic       rst_i       = 1'b1;
  logic       start_i     = 1'b0;
  logic       dual_mode_i = 1'b0;
  logic [7:0] word_i      = 8'h00;
  logic       ready_o, done_o, update_o, abort_o, mux_on_o, a_on, b_on, abort2, sclk_d, act;
  logic [7:0] cfg_word_o, cfg2, seen, w, lfsr;
  logic [4:0] mux_chan_o, ea, eb;
  logic [3:0] a_chan, b_chan;
  logic [7:0] corners [8] = '{8'h00, 8'h3F, 8'h9F, 8'h5A, 8'h1F, 8'h60, 8'h80, 8'h0C};
  int         failures = 0;
  int         compares = 0;
  int         aborts   = 0;
  int         nfall, i;

  mxsc_link_if lk ();
  mxsc_link_if lk2 ();

  mxsc_host u_mxsc_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .start_i(start_i),
    .word_i(word_i), .ready_o(ready_o), .done_o(done_o), .link(lk.host));
  mxsc_dev u_mxsc_dev (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .link(lk.dev),
    .dual_mode_i(dual_mode_i), .frame_active_o(act), .update_o(update_o), .abort_o(abort_o),
    .cfg_word_o(cfg_word_o), .mux_chan_o(mux_chan_o), .mux_on_o(mux_on_o),
    .bank_a_chan_o(a_chan), .bank_a_on_o(a_on), .bank_b_chan_o(b_chan), .bank_b_on_o(b_on));
  // Second device faces the bench, which breaks framing on purpose
  mxsc_dev u_mxsc_dev_b (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .link(lk2.dev),
    .dual_mode_i(dual_mode_i), .frame_active_o(), .update_o(), .abort_o(abort2),
    .cfg_word_o(cfg2), .mux_chan_o(), .mux_on_o(), .bank_a_chan_o(), .bank_a_on_o(),
    .bank_b_chan_o(), .bank_b_on_o());
  mxsc_link_asserts u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i),
    .ready_o(ready_o), .done_o(done_o), .sync_n(lk.sync_n), .sclk(lk.sclk), .din(lk.din),
    .update_o(update_o), .abort_o(abort_o), .cfg_word_o(cfg_word_o), .mux_on_o(mux_on_o),
    .frame_active_o(act));

  always #25 clk_sys_i = ~clk_sys_i;

  // ----------------------------------------------------------------
  // Wire watcher: bits as the device should take them
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i)
  begin
    sclk_d <= lk.sclk;
    if (!lk.sync_n && sclk_d && !lk.sclk)
    begin
      seen  <= {seen[6:0], lk.din};
      nfall <= nfall + 1;
    end
    if (abort2 === 1'b1)
      aborts <= aborts + 1;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Bank takes the word only when its select bit is low
  function automatic logic [4:0] bank_next(input logic [7:0] v, input logic sel_n,
                                           input logic [4:0] old);
    return (dual_mode_i && !sel_n) ? {~v[7], v[3:0]} : old;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic send(input logic [7:0] v);
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n == 200)
    begin
      failures++;
      report_and_stop();
    end
    nfall   = 0;
    word_i  = v;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n == 200)
    begin
      failures++;
      report_and_stop();
    end
    ea = bank_next(v, v[6], ea);
    eb = bank_next(v, v[5], eb);
    chk(16'(seen), 16'(v));
    chk(16'(nfall), 16'h0008);
    chk(16'(cfg_word_o), 16'(v));
    chk(16'(mux_on_o), 16'(!dual_mode_i && !v[7]));
    if (!dual_mode_i)
      chk(16'(mux_chan_o), 16'(v[4:0]));
    chk(16'({a_on, a_chan, b_on, b_chan}), 16'({ea, eb}));
  endtask

  // Drives the second link; extra bits go past the eighth edge
  task automatic bang(input logic [7:0] v, input int nb, input logic rel);
    int k;
    lk2.sync_n = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    for (k = 0; k < nb; k++)
    begin
      lk2.din  = v[7];
      v        = {v[6:0], ~v[7]};
      lk2.sclk = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      lk2.sclk = 1'b0;
      repeat (3) @(negedge clk_sys_i);
    end
    if (rel)
      lk2.sync_n = 1'b1;
    lk2.din = ~lk2.din;
    repeat (6) @(negedge clk_sys_i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    lk2.sync_n = 1'b1;
    lk2.sclk   = 1'b0;
    lk2.din    = 1'b0;
    ea         = 5'h00;
    eb         = 5'h00;
    lfsr       = 8'h29;
    repeat (16) @(negedge clk_sys_i);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    chk(16'({cfg_word_o, cfg2}), 16'h0000);
    chk(16'({mux_on_o, a_on, b_on, mux_chan_o, a_chan, b_chan}), 16'h0000);
    for (i = 0; i < 30; i++)
    begin
      lfsr = lfsr_next(lfsr);
      w    = (i < 8) ? corners[i] : lfsr;
      dual_mode_i = (i < 8) ? i[0] : lfsr[3];
      send(w);
    end
    dual_mode_i = 1'b0;
    chk(16'(lk.sync_n), 16'h0001);
    bang(8'h25, 10, 1'b0);
    chk(16'(cfg2), 16'h0025);
    lk2.sync_n = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk(16'(cfg2), 16'h0025);
    bang(8'hC3, 5, 1'b1);
    chk(16'({aborts[7:0], cfg2}), 16'h0125);
    report_and_stop();
  end
endmodule // testbench
